// >>> hw/interrupt_request_enable_bank.sv
// Interrupt request flags, enables and priority select for a 4-bit core
//
// Operation
// - Time base enable register, four taps
// - Level detector and melody enable register
// - Request bit set right after source event
// - Request needs master and source enable
// - Software writing one raises a request
// - Accepted request clears its own bit
// - Reset clears all request registers
// - External request register, pins three..zero
// - External interrupt n from port0 bit n
// - Serial and timer request register layout
// - Serial done events set serial flags
// - Timer overflow sets timer flags
// - Time base request register, four taps
// - Slowest tap flag set on falling edge
// - Other tap flags set on falling edge
// - Forward only request AND enable
// - Lowest start address presented first
// - Level detector and melody request register
`timescale 1ns/1ps
`include "irq_bank_defines.svh"

module interrupt_request_enable_bank
  import irq_bank_pkg::*;
(
  input  wire logic        sys_clk,              // 200 MHz system clock
  input  wire logic        reset,                // Synchronous, high
  input  wire logic [9:0]  avs_address,          // Byte address
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  port0Pin,             // Port 0 pins, async
  input  wire logic [3:0]  tbTap,                // Time base taps, async
  input  wire logic        timer0Overflow,       // One-cycle pulses
  input  wire logic        timer1Overflow,
  input  wire logic        serialRxDone,
  input  wire logic        serialTxDone,
  input  wire logic        melodyEnd,
  input  wire logic        levelDetectStart,
  input  wire logic [3:0]  extIrqEnable,         // Held outside the bank
  input  wire logic [3:0]  timerSerialIrqEnable, // Held outside the bank
  input  wire logic        masterIrqEnable,
  input  wire logic        cpuAccept,            // Core takes the request
  output logic             irqRequest,           // Request to the core
  output logic      [3:0]  irqSourceIndex,       // Winning source
  output logic      [7:0]  irqStartAddr,         // Its start address
  output logic             eventIrq              // Sticky event interrupt
);

  // =====================================================================
  // Storage
  nibble_t    tbEnQ;         // Time base tap enables
  logic [1:0] lmEnQ;         // Level detector / melody enables
  src_vec_t   reqQ;          // Request flags, all four registers
  src_vec_t   reqD;
  src_vec_t   evtStatQ;      // Sticky event status
  src_vec_t   evtStatD;
  src_vec_t   evtMaskQ;      // Event interrupt mask
  bus_state_e busQ;          // Bus answer state
  bus_state_e busD;
  logic [31:0] rdataQ;       // Registered read data

  // =====================================================================
  // Input synchronisers for pins and the time base taps
  logic [3:0] pinMetaQ;      // First stage, read by second stage only
  logic [3:0] pinSyncQ;      // Second stage
  logic [3:0] pinPrevQ;      // Previous synced level, for edges
  logic [3:0] tapMetaQ;
  logic [3:0] tapSyncQ;
  logic [3:0] tapPrevQ;

  // Two flops before any logic, a third for edge detection
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinMetaQ <= 4'h0;
      pinSyncQ <= 4'h0;
      pinPrevQ <= 4'h0;
      tapMetaQ <= 4'h0;
      tapSyncQ <= 4'h0;
      tapPrevQ <= 4'h0;
    end else begin
      pinMetaQ <= port0Pin;
      pinSyncQ <= pinMetaQ;
      pinPrevQ <= pinSyncQ;
      tapMetaQ <= tbTap;
      tapSyncQ <= tapMetaQ;
      tapPrevQ <= tapSyncQ;
    end
  end

  // Falling edges of the pins and the divider outputs
  wire [3:0] extFall = pinPrevQ & ~pinSyncQ;
  wire [3:0] tapFall = tapPrevQ & ~tapSyncQ;

  // =====================================================================
  // Hardware events in priority order
  wire src_vec_t hwEvt = {
    levelDetectStart,        // 13
    melodyEnd,               // 12
    tapFall,                 // 11..8: 1/16384 down to 1/1024
    serialTxDone,            // 7
    serialRxDone,            // 6
    timer1Overflow,          // 5
    timer0Overflow,          // 4
    extFall                  // 3..0
  };

  // Per-source enables in the same order
  wire src_vec_t enVec = {
    lmEnQ[1], lmEnQ[0], tbEnQ, timerSerialIrqEnable, extIrqEnable
  };

  // =====================================================================
  // Bus decode
  wire       busReq   = avs_read | avs_write;
  wire       busAct   = busReq & (busQ == BUS_ANSWER);
  wire       wrAct    = busAct & avs_write & avs_byteenable[0];
  wire       aligned  = (avs_address[1:0] == 2'b00);
  wire [7:0] regIdx   = avs_address[9:2];
  wire       selTbEn  = aligned & (regIdx == `IRB_IDX_TB_EN);
  wire       selLmEn  = aligned & (regIdx == `IRB_IDX_LM_EN);
  wire       selExtR  = aligned & (regIdx == `IRB_IDX_EXT_REQ);
  wire       selTsR   = aligned & (regIdx == `IRB_IDX_TS_REQ);
  wire       selTbR   = aligned & (regIdx == `IRB_IDX_TB_REQ);
  wire       selLmR   = aligned & (regIdx == `IRB_IDX_LM_REQ);
  wire       selStat  = aligned & (regIdx == `IRB_IDX_EVT_STAT);
  wire       selMask  = aligned & (regIdx == `IRB_IDX_EVT_MASK);
  wire nibble_t wNib  = avs_writedata[3:0];

  // Which request bits a software write touches, and with what
  wire src_vec_t swWrMask = {
    {2{wrAct & selLmR}},
    {4{wrAct & selTbR}},
    {4{wrAct & selTsR}},
    {4{wrAct & selExtR}}
  };
  wire src_vec_t swWrVal = {wNib[1:0], wNib, wNib, wNib};

  // =====================================================================
  // Gating and priority
  wire src_vec_t pendEn = reqQ & enVec;

  // Lowest index wins, that is the lowest start address
  function automatic logic [3:0] lowestSet(input src_vec_t v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = `IRB_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  wire [3:0] winIdx   = lowestSet(pendEn);
  wire       anyPend  = |pendEn;
  assign irqRequest     = masterIrqEnable & anyPend;
  assign irqSourceIndex = winIdx;
  assign irqStartAddr   = `IRB_VEC_BASE + {3'b000, winIdx, 1'b0};

  // Clear mask for the accepted source only
  wire src_vec_t accClr = (cpuAccept & irqRequest) ?
                          src_vec_t'(14'h0001 << winIdx) : '0;

  // =====================================================================
  // Next value of each request flag, one generate per source
  genvar g;
  generate
    for (g = 0; g < `IRB_NUM_SRC; g++) begin : gReq
      // Event first so a clear in the same cycle cannot drop it
      assign reqD[g] = hwEvt[g] |
                       (swWrMask[g] ? swWrVal[g] :
                        (reqQ[g] & ~accClr[g]));
      // Sticky event status, set beats write-one-to-clear
      assign evtStatD[g] = hwEvt[g] |
                           (evtStatQ[g] &
                            ~(wrAct & selStat & avs_writedata[g]));
    end
  endgenerate

  // Request flags update on the edge after the event cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reqQ <= `IRB_RST_REQ;
    end else begin
      reqQ <= reqD;
    end
  end

  // =====================================================================
  // Enable registers, only low bits are stored
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tbEnQ <= `IRB_RST_EN;
      lmEnQ <= 2'b00;
    end else begin
      if (wrAct & selTbEn) begin
        tbEnQ <= wNib;
      end
      if (wrAct & selLmEn) begin
        lmEnQ <= wNib[1:0];
      end
    end
  end

  // Event status and mask for the secondary interrupt line
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      evtStatQ <= '0;
      evtMaskQ <= '0;
    end else begin
      evtStatQ <= evtStatD;
      if (wrAct & selMask) begin
        evtMaskQ <= avs_writedata[13:0];
      end
    end
  end

  // Level output, high while any unmasked status bit is set
  assign eventIrq = |(evtStatQ & evtMaskQ);

  // =====================================================================
  // Read selection; unused and unmapped bits read zero
  wire [31:0] rdMux =
    selTbEn ? {28'h0, tbEnQ}                                   :
    selLmEn ? {30'h0, lmEnQ}                                   :
    selExtR ? {28'h0, reqQ[`IRB_POS_EXT +: 4]}                 :
    selTsR  ? {28'h0, reqQ[`IRB_POS_TS +: 4]}                  :
    selTbR  ? {28'h0, reqQ[`IRB_POS_TB +: 4]}                  :
    selLmR  ? {30'h0, reqQ[`IRB_POS_LM +: 2]}                  :
    selStat ? {18'h0, evtStatQ}                                :
    selMask ? {18'h0, evtMaskQ}                                :
              32'h0;

  // =====================================================================
  // Bus slave: one wait cycle, then answer; data from a flop
  always_comb begin
    busD = busQ;
    case (busQ)
      BUS_IDLE: begin
        if (busReq) begin
          busD = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        busD = BUS_IDLE;
      end
      default: begin
        busD = BUS_IDLE;
      end
    endcase
  end

  // State and read data capture, data stays until next read
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busQ   <= BUS_IDLE;
      rdataQ <= 32'h0;
    end else begin
      busQ <= busD;
      if (busQ == BUS_IDLE && avs_read) begin
        rdataQ <= rdMux;
      end
    end
  end

  // Wait is released in the answer cycle only
  assign avs_waitrequest = busReq & (busQ != BUS_ANSWER);
  assign avs_readdata    = rdataQ;

  // =====================================================================
  // Checks
  AST_RESET_CLEARS: assert property (@(posedge sys_clk)
    reset |=> (reqQ == '0 && tbEnQ == 4'h0 && lmEnQ == 2'b00))
    else $error("Flags or enables not zero after reset");

  AST_TB_EN_WRITE: assert property (@(posedge sys_clk)
    disable iff (reset)
    (wrAct && selTbEn) |=> (tbEnQ == $past(avs_writedata[3:0])))
    else $error("Time base enable write lost");

  AST_LM_EN_READ: assert property (@(posedge sys_clk)
    disable iff (reset)
    (avs_read && selLmEn && busQ == BUS_IDLE) |=>
      (avs_readdata[31:2] == 30'h0 && avs_readdata[1:0] == $past(lmEnQ)))
    else $error("Level/melody enable read wrong");

  AST_EVENT_SETS: assert property (@(posedge sys_clk)
    disable iff (reset)
    (hwEvt != '0) |=> ((reqQ & $past(hwEvt)) == $past(hwEvt)))
    else $error("Event did not set its request flag");

  AST_GATED_REQ: assert property (@(posedge sys_clk)
    disable iff (reset)
    irqRequest == (masterIrqEnable && ((reqQ & enVec) != '0)))
    else $error("Request gating wrong");

  AST_SW_SET: assert property (@(posedge sys_clk)
    disable iff (reset)
    (wrAct && selExtR && hwEvt == '0) |=>
      (reqQ[3:0] == $past(avs_writedata[3:0])))
    else $error("Software write to requests not taken");

  AST_ACCEPT_CLEARS: assert property (@(posedge sys_clk)
    disable iff (reset)
    (cpuAccept && irqRequest && !wrAct && hwEvt == '0) |=>
      !reqQ[$past(winIdx)])
    else $error("Accepted request not cleared");

  AST_TAP_FALL: assert property (@(posedge sys_clk)
    disable iff (reset)
    $fell(tapSyncQ[3]) |=> reqQ[`IRB_POS_TB + 3])
    else $error("Slow tap falling edge missed");

  AST_PRIORITY: assert property (@(posedge sys_clk)
    disable iff (reset)
    irqRequest |-> (pendEn[winIdx] &&
      ((pendEn & ((14'h0001 << winIdx) - 14'h0001)) == '0)))
    else $error("Higher priority source skipped");

  AST_SET_WINS: assert property (@(posedge sys_clk)
    disable iff (reset)
    ((accClr & hwEvt) != '0) |=>
      ((reqQ & $past(accClr & hwEvt)) == $past(accClr & hwEvt)))
    else $error("Clear beat a same-cycle event");

  AST_BUS_ANSWER: assert property (@(posedge sys_clk)
    disable iff (reset)
    (busReq && busQ == BUS_IDLE) |=> !avs_waitrequest [*1])
    else $error("Bus answer not given after one wait");

  // Pin edges pass the synchroniser, so the flag trails the pin
  AST_EXT_FALL: assert property (@(posedge sys_clk)
    disable iff (reset)
    (extFall != 4'h0) |=> ((reqQ[3:0] & $past(extFall)) == $past(extFall)))
    else $error("Pin falling edge did not set its flag");

  // The three faster taps share the slow tap's edge logic
  AST_TAP_FALL_LOW: assert property (@(posedge sys_clk)
    disable iff (reset)
    (tapFall[2:0] != 3'b000) |=>
      ((reqQ[`IRB_POS_TB +: 3] & $past(tapFall[2:0])) == $past(tapFall[2:0])))
    else $error("Fast tap falling edge missed");

  // A software write replaces the whole tap request field
  AST_SW_TAP_SET: assert property (@(posedge sys_clk)
    disable iff (reset)
    (wrAct && selTbR && hwEvt == '0) |=>
      (reqQ[`IRB_POS_TB +: 4] == $past(avs_writedata[3:0])))
    else $error("Software write to tap requests not taken");

  // Read data is captured at the request's first edge
  AST_TS_REQ_READ: assert property (@(posedge sys_clk)
    disable iff (reset)
    (avs_read && selTsR && busQ == BUS_IDLE) |=>
      (avs_readdata == {28'h0, $past(reqQ[`IRB_POS_TS +: 4])}))
    else $error("Timer/serial request read wrong");

  COV_SW_INT: cover property (@(posedge sys_clk) disable iff (reset)
    (wrAct && selTbR) ##1 irqRequest);
  COV_ACCEPT: cover property (@(posedge sys_clk) disable iff (reset)
    cpuAccept && irqRequest);
  COV_TWO_PEND: cover property (@(posedge sys_clk) disable iff (reset)
    irqRequest && ($countones(pendEn) > 1));
  COV_EVT_IRQ: cover property (@(posedge sys_clk) disable iff (reset)
    eventIrq);
  // Rare race: the core takes a flag as its source fires again
  COV_SET_WINS: cover property (@(posedge sys_clk) disable iff (reset)
    (accClr & hwEvt) != '0);

endmodule

// >>> pkg/irq_bank_defines.svh
// Register offsets, field positions, reset values for the request bank
`ifndef IRQ_BANK_DEFINES_SVH
`define IRQ_BANK_DEFINES_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define IRB_IDX_TB_EN      8'h52
`define IRB_IDX_LM_EN      8'h53
`define IRB_IDX_EXT_REQ    8'h55
`define IRB_IDX_TS_REQ     8'h56
`define IRB_IDX_TB_REQ     8'h57
`define IRB_IDX_LM_REQ     8'h58
`define IRB_IDX_EVT_STAT   8'h60
`define IRB_IDX_EVT_MASK   8'h61

// =====================================================================
// Reset values
`define IRB_RST_EN         4'h0
`define IRB_RST_REQ        14'h0000

// =====================================================================
// Positions in the 14-bit source vector (also the priority order)
`define IRB_POS_EXT        0
`define IRB_POS_TS         4
`define IRB_POS_TB         8
`define IRB_POS_LM         12
`define IRB_NUM_SRC        14

// Vector start address of source 0 (sources are two apart)
`define IRB_VEC_BASE       8'h10

`endif

// >>> pkg/irq_bank_pkg.sv
// Types shared by the interrupt request and enable bank
package irq_bank_pkg;

  // =====================================================================
  // One bit per interrupt source, index equals priority
  typedef logic [13:0] src_vec_t;
  // Four-bit data nibble of the core's registers
  typedef logic [3:0]  nibble_t;

  // Bus slave answer sequence
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_e;

endpackage

// >>> testbench/cpu_core_model.sv
// Behavioural model of the core that accepts interrupt requests
`timescale 1ns/1ps

module cpu_core_model (
  input  wire logic       sys_clk,     // System clock
  input  wire logic       reset,       // Synchronous, high
  input  wire logic       irqRequest,  // Request from the bank
  input  wire logic       acceptOn,    // Core willing to take requests
  input  wire logic [3:0] latency,     // Cycles before accepting
  output logic            cpuAccept,   // One-cycle accept pulse
  output logic      [7:0] acceptCount  // Requests taken so far
);
  // =====================================================================
  // Accept sequencing
  logic [3:0] waitCount_q;  // Cycles the request has waited
  logic [7:0] taken_q;      // Accept tally

  assign acceptCount = taken_q;

  // Pulse accept only while a request is really presented
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cpuAccept   <= 1'b0;
      waitCount_q <= 4'h0;
      taken_q     <= 8'h00;
    end else if (cpuAccept) begin
      // One pulse per request, the flag drops at this edge
      cpuAccept   <= 1'b0;
      waitCount_q <= 4'h0;
    end else if (acceptOn && irqRequest) begin
      if (waitCount_q == latency) begin
        cpuAccept <= 1'b1;
        taken_q   <= taken_q + 8'h01;
      end else begin
        // Slow core keeps the request on hold
        waitCount_q <= waitCount_q + 4'h1;
      end
    end else begin
      waitCount_q <= 4'h0;
    end
  end
endmodule

// >>> testbench/interrupt_request_enable_bank_tb.sv
// Self-checking bench for the interrupt request and enable bank
`timescale 1ns/1ps

module interrupt_request_enable_bank_tb;
  // =====================================================================
  // Signals
  logic        sys_clk = 1'b0;          // 200 MHz
  logic        reset = 1'b1;            // Synchronous, high
  logic [9:0]  avs_address = 10'h000;   // Byte address
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  port0Pin = 4'hf;         // High, so a fall is an edge
  logic [3:0]  tbTap = 4'hf;
  logic [5:0]  pulseV = 6'h00;          // Event pulses
  logic [3:0]  extIrqEnable = 4'h0;
  logic [3:0]  timerSerialIrqEnable = 4'h0;
  logic        masterIrqEnable = 1'b0;
  logic        cpuAccept, irqRequest, eventIrq;
  logic [3:0]  irqSourceIndex;
  logic [7:0]  irqStartAddr, acceptCount;
  logic        acceptOn = 1'b0;         // Core model enable
  logic [3:0]  latency = 4'h3;          // Slow core first
  int          n_fail = 0;
  int          check_count = 0;
  int          accN = 0;                // Accepts seen in priority test
  int          expOrder [6] = '{4, 5, 6, 7, 12, 13};
  logic [31:0] rdv;

  always #2.5 sys_clk = ~sys_clk;

  interrupt_request_enable_bank interrupt_request_enable_bank_inst (
    .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port0Pin(port0Pin), .tbTap(tbTap), .timer0Overflow(pulseV[0]),
    .timer1Overflow(pulseV[1]), .serialRxDone(pulseV[2]),
    .serialTxDone(pulseV[3]), .melodyEnd(pulseV[4]),
    .levelDetectStart(pulseV[5]), .extIrqEnable(extIrqEnable),
    .timerSerialIrqEnable(timerSerialIrqEnable),
    .masterIrqEnable(masterIrqEnable), .cpuAccept(cpuAccept),
    .irqRequest(irqRequest), .irqSourceIndex(irqSourceIndex),
    .irqStartAddr(irqStartAddr), .eventIrq(eventIrq));

  cpu_core_model cpu_core_model_inst (
    .sys_clk(sys_clk), .reset(reset), .irqRequest(irqRequest),
    .acceptOn(acceptOn), .latency(latency), .cpuAccept(cpuAccept),
    .acceptCount(acceptCount));

  // =====================================================================
  // Shared tasks
  task automatic final_report();
    $display("Checks %0d, failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // Avalon cycle: hold until waitrequest is sampled low
  task automatic bus(logic wr, logic [7:0] idx, logic [31:0] wd,
                     logic [3:0] be, output logic [31:0] rd);
    int i;
    @(posedge sys_clk);
    avs_address    <= {idx, 2'b00};
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      $display("Error waitrequest expected 0 seen 1");
      n_fail++;
      final_report();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(logic [7:0] idx, logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, 4'h1, d);
    // The store lands at the answer edge, so look one edge later
    @(posedge sys_clk);
  endtask

  task automatic rd(string what, logic [7:0] idx, logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 32'h0, 4'h0, d);
    chk(what, exp, d);
  endtask

  task automatic pulse(int k);
    @(posedge sys_clk);
    pulseV <= 6'h01 << k;
    @(posedge sys_clk);
    pulseV <= 6'h00;
  endtask

  // Order and start address of every accept in the priority test
  always @(posedge sys_clk) begin
    if (cpuAccept === 1'b1 && irqRequest === 1'b1 && accN < 6) begin
      chk("accept index", expOrder[accN], irqSourceIndex);
      chk("start addr", 8'h10 + 2 * expOrder[accN], irqStartAddr);
      accN++;
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    final_report();
  end

  // =====================================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    // Reset values, unmapped place reads zero
    foreach (expOrder[j]) rd("reset reg", 8'h52 + j[7:0], 32'h0);
    rd("reset 58", 8'h58, 32'h0);
    rd("reset status", 8'h60, 32'h0);
    rd("unmapped", 8'h54, 32'h0);
    $display("Test reset done");
    // Enable registers, lane 0 off stores nothing
    wr(8'h52, 32'hf);
    rd("tb enable", 8'h52, 32'hf);
    bus(1'b1, 8'h52, 32'h5, 4'h0, rdv);
    rd("tb enable be0", 8'h52, 32'hf);
    wr(8'h53, 32'hf);
    rd("lm enable", 8'h53, 32'h3);
    wr(8'h52, 32'h0);
    $display("Test enables done");
    // Source events set their flags, nothing reaches the core yet
    for (int k = 0; k < 6; k++) pulse(k);
    rd("ts request", 8'h56, 32'hf);
    rd("lm request", 8'h58, 32'h3);
    chk("irq master off", 1'b0, irqRequest);
    rd("event status", 8'h60, 32'h30f0);
    wr(8'h61, 32'h0010);
    chk("event irq", 1'b1, eventIrq);
    wr(8'h60, 32'h0010);
    chk("event irq cleared", 1'b0, eventIrq);
    rd("status w1c", 8'h60, 32'h30e0);
    $display("Test events done");
    // Priority and accept clearing, slow core
    timerSerialIrqEnable <= 4'hf;
    masterIrqEnable      <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk("first index", 4'h4, irqSourceIndex);
    chk("first addr", 8'h18, irqStartAddr);
    acceptOn <= 1'b1;
    for (int i = 0; i < 200 && acceptCount < 8'd6; i++) @(posedge sys_clk);
    acceptOn <= 1'b0;
    // Let the monitor count the last accept before comparing
    @(posedge sys_clk);
    chk("accepts", 6, accN);
    rd("ts after accept", 8'h56, 32'h0);
    rd("lm after accept", 8'h58, 32'h0);
    $display("Test priority done");
    // Software request needs its enable and the master enable
    wr(8'h57, 32'h1);
    chk("sw req no enable", 1'b0, irqRequest);
    wr(8'h52, 32'h1);
    chk("sw req", 1'b1, irqRequest);
    chk("sw index", 4'h8, irqSourceIndex);
    masterIrqEnable <= 1'b0;
    @(posedge sys_clk);
    chk("sw master off", 1'b0, irqRequest);
    masterIrqEnable <= 1'b1;
    latency  <= 4'h0;
    acceptOn <= 1'b1;
    // Master enable must settle before the loop looks at the request
    @(posedge sys_clk);
    for (int i = 0; i < 50 && irqRequest !== 1'b0; i++) @(posedge sys_clk);
    acceptOn <= 1'b0;
    rd("prompt accept", 8'h57, 32'h0);
    // Software write to the pin request register, enables off
    wr(8'h55, 32'h5);
    rd("ext sw request", 8'h55, 32'h5);
    wr(8'h55, 32'h0);
    // Accept and timer event on one flag in one cycle: flag stays
    wr(8'h56, 32'h1);
    acceptOn <= 1'b1;
    @(posedge sys_clk);
    pulseV   <= 6'h01;
    @(posedge sys_clk);
    pulseV   <= 6'h00;
    acceptOn <= 1'b0;
    rd("set beats accept", 8'h56, 32'h1);
    wr(8'h56, 32'h0);
    $display("Test software done");
    // Falling pin and tap edges, one bit at a time
    for (int n = 0; n < 4; n++) begin
      @(posedge sys_clk);
      port0Pin[n] <= 1'b0;
      tbTap[n]    <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rd("ext request", 8'h55, (32'h2 << n) - 1);
      rd("tap request", 8'h57, (32'h2 << n) - 1);
    end
    $display("Test edges done");
    final_report();
  end
endmodule
